// *** shared/ptm_pkg.sv ***
package ptm_pkg;

  // ****************************************************************
  // string geometry
  // ****************************************************************
  localparam int unsigned STR_LEN   = 64;                 // bytes in one trace string
  localparam int unsigned IDX_W     = 6;                  // byte index width
  localparam logic [5:0]  IDX_FIRST = 6'h00;
  localparam logic [5:0]  IDX_LAST  = 6'h3F;
  localparam logic [5:0]  IDX_STEP  = 6'h01;
  localparam logic [7:0]  NULL_BYTE = 8'h00;              // empty string filler

  // ****************************************************************
  // modes and selectors
  // ****************************************************************
  typedef enum logic [1:0] {
    PTM_MODE_OFF    = 2'b00,
    PTM_MODE_AUTO   = 2'b01,
    PTM_MODE_MANUAL = 2'b10
  } ptm_mode_t;

  typedef enum logic [1:0] {
    PTM_SEL_TX   = 2'b00,
    PTM_SEL_EXP  = 2'b01,
    PTM_SEL_RCVD = 2'b10
  } ptm_sel_t;

endpackage

// *** shared/ptm_cmp_if.sv ***
`timescale 1ns/100ps
`default_nettype none

// byte-serial link between the receive sequencer and the comparator
interface ptm_cmp_if;
  logic       valid;      // aligned received byte present
  logic       first;      // byte 0 of a string
  logic       last;       // byte 63 of a string
  logic [7:0] rx_byte;
  logic [7:0] base_byte;  // baseline byte at the same index
  logic       done;       // one-cycle pulse after the last byte
  logic       diff;       // string differed, valid with done

  modport seq (output valid, first, last, rx_byte, base_byte, input done, diff);
  modport cmp (input valid, first, last, rx_byte, base_byte, output done, diff);
endinterface

`default_nettype wire

// *** verilog/ptm_str_cmp.sv ***
`timescale 1ns/100ps
`default_nettype none

module ptm_str_cmp (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  ptm_cmp_if.cmp    cmp_if
);

  // ****************************************************************
  // running mismatch over one string
  // ****************************************************************
  logic acc_q;
  logic acc_d;
  logic byte_ne;

  // compare this byte and fold into the string result
  always_comb begin
    byte_ne = (cmp_if.rx_byte != cmp_if.base_byte);
    acc_d   = cmp_if.first ? byte_ne : (acc_q | byte_ne);
  end

  // accumulator, restarted by every byte 0
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= 1'b0;
    end else if (cmp_if.valid) begin
      acc_q <= acc_d;
    end
  end

  // ****************************************************************
  // result at end of string
  // ****************************************************************
  logic done_q;
  logic diff_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
      diff_q <= 1'b0;
    end else begin
      done_q <= cmp_if.valid & cmp_if.last;
      if (cmp_if.valid & cmp_if.last) begin
        diff_q <= acc_d;
      end
    end
  end

  assign cmp_if.done = done_q;
  assign cmp_if.diff = diff_q;

  // a differing last byte must always give a differing result
  last_byte_diff_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmp_if.valid && cmp_if.last && (cmp_if.rx_byte != cmp_if.base_byte)
      |=> cmp_if.done && cmp_if.diff)
    else $error("differing last byte not reported");

endmodule

`default_nettype wire

// *** verilog/ptm_top.sv ***
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - trace string is 64 repeating J1 bytes
// - alarm when received string differs from baseline
// - auto mode learns first complete string
// - manual mode compares against provisioned expected
// - unprovisioned transmit string sends null bytes
// - defaults: mode off, transmit and expected strings null
// - receive-only build has no transmit path
module ptm_top #(
  parameter bit TX_EN = 1'b1
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       mode_wr_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       defaults_i,
  input  wire logic       prov_wr_i,
  input  wire logic [1:0] prov_sel_i,
  input  wire logic [5:0] prov_addr_i,
  input  wire logic [7:0] prov_data_i,
  input  wire logic       rd_req_i,
  input  wire logic [1:0] rd_sel_i,
  input  wire logic [5:0] rd_addr_i,
  output logic      [7:0] rd_data_o,
  output logic            rd_valid_o,
  input  wire logic       rx_valid_i,
  input  wire logic       rx_first_i,
  input  wire logic [7:0] rx_byte_i,
  input  wire logic       tx_req_i,
  output logic      [7:0] tx_byte_o,
  output logic            tx_valid_o,
  output logic            tx_first_o,
  output logic      [1:0] mode_o,
  output logic            learned_o,
  output logic            alarm_o
);

  // ****************************************************************
  // provisioning state
  // ****************************************************************
  ptm_pkg::ptm_mode_t mode_q;
  logic [7:0]         tx_mem   [ptm_pkg::STR_LEN];
  logic [7:0]         exp_mem  [ptm_pkg::STR_LEN];
  logic [7:0]         lrn_mem  [ptm_pkg::STR_LEN];
  logic [7:0]         buf_mem  [ptm_pkg::STR_LEN];
  logic [7:0]         rcvd_mem [ptm_pkg::STR_LEN];
  logic               mode_chg;

  assign mode_chg = defaults_i | mode_wr_i;

  // mode register; defaults force it off
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= ptm_pkg::PTM_MODE_OFF;
    end else if (defaults_i) begin
      mode_q <= ptm_pkg::PTM_MODE_OFF;
    end else if (mode_wr_i) begin
      unique case (mode_i)
        ptm_pkg::PTM_MODE_AUTO:   mode_q <= ptm_pkg::PTM_MODE_AUTO;
        ptm_pkg::PTM_MODE_MANUAL: mode_q <= ptm_pkg::PTM_MODE_MANUAL;
        default:                  mode_q <= ptm_pkg::PTM_MODE_OFF;  // off and unused code
      endcase
    end
  end

  // transmit and expected strings, null after reset or defaults
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < ptm_pkg::STR_LEN; i++) begin
        tx_mem[i]  <= ptm_pkg::NULL_BYTE;
        exp_mem[i] <= ptm_pkg::NULL_BYTE;
      end
    end else if (defaults_i) begin
      for (int i = 0; i < ptm_pkg::STR_LEN; i++) begin
        tx_mem[i]  <= ptm_pkg::NULL_BYTE;
        exp_mem[i] <= ptm_pkg::NULL_BYTE;
      end
    end else if (prov_wr_i) begin
      if (TX_EN && prov_sel_i == ptm_pkg::PTM_SEL_TX) begin
        tx_mem[prov_addr_i] <= prov_data_i;
      end
      if (prov_sel_i == ptm_pkg::PTM_SEL_EXP) begin
        exp_mem[prov_addr_i] <= prov_data_i;
      end
    end
  end

  // ****************************************************************
  // transmit sequencer
  // ****************************************************************
  logic [5:0] tx_idx_q;

  // one byte per request, cycling over 64 positions
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_idx_q   <= ptm_pkg::IDX_FIRST;
      tx_byte_o  <= ptm_pkg::NULL_BYTE;
      tx_valid_o <= 1'b0;
      tx_first_o <= 1'b0;
    end else begin
      tx_valid_o <= TX_EN & tx_req_i;
      if (TX_EN && tx_req_i) begin
        tx_byte_o  <= tx_mem[tx_idx_q];
        tx_first_o <= (tx_idx_q == ptm_pkg::IDX_FIRST);
        tx_idx_q   <= tx_idx_q + ptm_pkg::IDX_STEP;
      end
    end
  end

  // ****************************************************************
  // receive alignment
  // ****************************************************************
  logic [5:0] rx_cnt_q;
  logic       aligned_q;
  logic [5:0] rx_idx;
  logic       rx_take;
  logic       rx_last;

  assign rx_idx  = rx_first_i ? ptm_pkg::IDX_FIRST : rx_cnt_q;
  assign rx_take = rx_valid_i & (rx_first_i | aligned_q);
  assign rx_last = rx_take & (rx_idx == ptm_pkg::IDX_LAST);

  // byte counter; a string starts only at a first marker
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_cnt_q  <= ptm_pkg::IDX_FIRST;
      aligned_q <= 1'b0;
    end else if (rx_take) begin
      rx_cnt_q  <= rx_idx + ptm_pkg::IDX_STEP;
      aligned_q <= ~rx_last;
    end
  end

  // ****************************************************************
  // received string hold
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < ptm_pkg::STR_LEN; i++) begin
        buf_mem[i]  <= ptm_pkg::NULL_BYTE;
        rcvd_mem[i] <= ptm_pkg::NULL_BYTE;
      end
    end else if (rx_take) begin
      buf_mem[rx_idx] <= rx_byte_i;
      if (rx_last) begin
        for (int i = 0; i < ptm_pkg::STR_LEN - 1; i++) begin
          rcvd_mem[i] <= buf_mem[i];
        end
        rcvd_mem[ptm_pkg::STR_LEN - 1] <= rx_byte_i;
      end
    end
  end

  // ****************************************************************
  // baseline learning
  // ****************************************************************
  logic learned_q;
  logic learn_act_q;
  logic is_auto;

  assign is_auto = (mode_q == ptm_pkg::PTM_MODE_AUTO);

  // capture the first complete string seen in auto mode
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      learned_q   <= 1'b0;
      learn_act_q <= 1'b0;
    end else if (mode_chg) begin
      learned_q   <= 1'b0;
      learn_act_q <= 1'b0;
    end else if (rx_take) begin
      if (rx_first_i) begin
        learn_act_q <= is_auto & ~learned_q & ~rx_last;
      end
      if (rx_last && is_auto && (learn_act_q || rx_first_i) && !learned_q) begin
        learned_q   <= 1'b1;
        learn_act_q <= 1'b0;
      end
    end
  end

  // learned string store
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < ptm_pkg::STR_LEN; i++) begin
        lrn_mem[i] <= ptm_pkg::NULL_BYTE;
      end
    end else if (rx_take && is_auto && !learned_q && (learn_act_q || rx_first_i)) begin
      lrn_mem[rx_idx] <= rx_byte_i;
    end
  end

  // ****************************************************************
  // comparison and alarm
  // ****************************************************************
  ptm_cmp_if cmp_bus ();
  logic cmp_en_q;
  logic alarm_q;

  assign cmp_bus.valid     = rx_take;
  assign cmp_bus.first     = rx_first_i;
  assign cmp_bus.last      = rx_last;
  assign cmp_bus.rx_byte   = rx_byte_i;
  assign cmp_bus.base_byte = is_auto ? lrn_mem[rx_idx] : exp_mem[rx_idx];

  ptm_str_cmp u_cmp (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .cmp_if  (cmp_bus)
  );

  // decide at byte 0 whether this string is checked
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_en_q <= 1'b0;
    end else if (mode_chg) begin
      cmp_en_q <= 1'b0;
    end else if (rx_take && rx_first_i) begin
      cmp_en_q <= (mode_q == ptm_pkg::PTM_MODE_MANUAL) | (is_auto & learned_q);
    end
  end

  // alarm follows each checked string: set on differ, clear on match
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_q <= 1'b0;
    end else if (mode_chg || mode_q == ptm_pkg::PTM_MODE_OFF) begin
      alarm_q <= 1'b0;
    end else if (cmp_bus.done && cmp_en_q) begin
      alarm_q <= cmp_bus.diff;
    end
  end

  assign alarm_o   = alarm_q;
  assign learned_o = learned_q;
  assign mode_o    = mode_q;

  // ****************************************************************
  // readback
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o  <= ptm_pkg::NULL_BYTE;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_req_i;
      if (rd_req_i) begin
        unique case (rd_sel_i)
          ptm_pkg::PTM_SEL_TX:   rd_data_o <= TX_EN ? tx_mem[rd_addr_i] : ptm_pkg::NULL_BYTE;
          ptm_pkg::PTM_SEL_EXP:  rd_data_o <= exp_mem[rd_addr_i];
          ptm_pkg::PTM_SEL_RCVD: rd_data_o <= rcvd_mem[rd_addr_i];
          default:               rd_data_o <= ptm_pkg::NULL_BYTE;
        endcase
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  alarm_off_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    mode_q == ptm_pkg::PTM_MODE_OFF |-> !alarm_q)
    else $error("alarm raised while mode off");

  defaults_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    defaults_i |=> mode_q == ptm_pkg::PTM_MODE_OFF && !alarm_q && !learned_q
      && exp_mem[ptm_pkg::IDX_FIRST] == ptm_pkg::NULL_BYTE)
    else $error("defaults did not restore off and null");

  alarm_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmp_bus.done && cmp_en_q && !cmp_bus.diff && !mode_chg
      && mode_q != ptm_pkg::PTM_MODE_OFF |=> !alarm_q)
    else $error("alarm not cleared on matching string");

  alarm_raise_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmp_bus.done && cmp_en_q && cmp_bus.diff && !mode_chg
      && mode_q != ptm_pkg::PTM_MODE_OFF |=> alarm_q)
    else $error("alarm not raised on differing string");

  learn_done_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_last && is_auto && learn_act_q && !learned_q && !mode_chg |=> learned_q)
    else $error("first auto string not learned");

  no_tx_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !TX_EN |-> !tx_valid_o)
    else $error("receive-only build transmitted");

  tx_wrap_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_req_i && tx_idx_q == ptm_pkg::IDX_LAST |=> tx_idx_q == ptm_pkg::IDX_FIRST)
    else $error("transmit index did not wrap after 64");

  rcvd_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_last |=> rcvd_mem[ptm_pkg::IDX_LAST] == $past(rx_byte_i))
    else $error("received string not held");

  manual_base_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    mode_q == ptm_pkg::PTM_MODE_MANUAL |-> cmp_bus.base_byte == exp_mem[rx_idx])
    else $error("manual baseline is not expected string");

  rd_answer_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_req_i |=> rd_valid_o ##1 (!rd_valid_o || $past(rd_req_i)))
    else $error("readback valid misplaced");

endmodule

`default_nettype wire

// *** dv/ptm_peer.sv ***
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// far-end path endpoint: one 64-byte trace string per go pulse
// ****************************************************************
module ptm_peer (
  input  wire logic       mclk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] seed_i,
  input  wire logic       slow_i,
  output logic            rx_valid_o,
  output logic            rx_first_o,
  output logic      [7:0] rx_byte_o,
  output logic            busy_o
);
  logic [7:0] base;
  logic       gap;

  // idle line until the first go pulse; byte k is base plus k;
  // slow mode leaves an idle cycle after each byte
  initial begin
    rx_valid_o = 1'b0;
    rx_first_o = 1'b0;
    rx_byte_o  = 8'h00;
    busy_o     = 1'b0;
    forever begin
      @(posedge mclk_i iff go_i);
      base   = seed_i;
      gap    = slow_i;
      busy_o = 1'b1;
      for (int k = 0; k < 64; k++) begin
        #1;
        rx_valid_o = 1'b1;
        rx_first_o = (k == 0);
        rx_byte_o  = base + 8'(k);
        @(posedge mclk_i);
        if (gap) begin
          #1;
          rx_valid_o = 1'b0;
          rx_byte_o  = ~rx_byte_o; // stale data must not look like a byte
          @(posedge mclk_i);
        end
      end
      busy_o = 1'b0; // dropped on the last edge so the bench never races it
      #1;
      rx_valid_o = 1'b0;
      rx_first_o = 1'b0;
      rx_byte_o  = ~rx_byte_o;
    end
  end
endmodule

`default_nettype wire

// *** dv/path_trace_monitor_bench.sv ***
`timescale 1ns/100ps
`default_nettype none

module path_trace_monitor_bench;
  logic       mclk_i, rst_n_i, mode_wr_i, defaults_i, prov_wr_i, rd_req_i, tx_req_i;
  logic [1:0] mode_i, prov_sel_i, rd_sel_i, mode_o;
  logic [5:0] prov_addr_i, rd_addr_i;
  logic [7:0] prov_data_i, rd_data_o, tx_byte_o, rx_byte_i, seed, got, xo_data;
  logic       rd_valid_o, rx_valid_i, rx_first_i, tx_valid_o, tx_first_o;
  logic       learned_o, alarm_o, go, slow, busy, xo_txv, xo_alarm;
  int         failures, n_checks;

  ptm_top #(.TX_EN(1'b1)) u_dut (.mclk_i, .rst_n_i, .mode_wr_i, .mode_i, .defaults_i,
    .prov_wr_i, .prov_sel_i, .prov_addr_i, .prov_data_i, .rd_req_i, .rd_sel_i, .rd_addr_i,
    .rd_data_o, .rd_valid_o, .rx_valid_i, .rx_first_i, .rx_byte_i, .tx_req_i, .tx_byte_o,
    .tx_valid_o, .tx_first_o, .mode_o, .learned_o, .alarm_o);

  // receive-only variant fed the same stimulus
  ptm_top #(.TX_EN(1'b0)) u_rxo (.mclk_i, .rst_n_i, .mode_wr_i, .mode_i, .defaults_i,
    .prov_wr_i, .prov_sel_i, .prov_addr_i, .prov_data_i, .rd_req_i, .rd_sel_i, .rd_addr_i,
    .rd_data_o(xo_data), .rd_valid_o(), .rx_valid_i, .rx_first_i, .rx_byte_i, .tx_req_i,
    .tx_byte_o(), .tx_valid_o(xo_txv), .tx_first_o(), .mode_o(), .learned_o(),
    .alarm_o(xo_alarm));

  ptm_peer u_peer (.mclk_i, .go_i(go), .seed_i(seed), .slow_i(slow),
    .rx_valid_o(rx_valid_i), .rx_first_o(rx_first_i), .rx_byte_o(rx_byte_i), .busy_o(busy));

  // 200 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [1:0] s, input logic [5:0] a, input logic [7:0] d);
    prov_wr_i   = 1'b1;
    prov_sel_i  = s;
    prov_addr_i = a;
    prov_data_i = d;
    tick(1);
    prov_wr_i = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [1:0] s, input logic [5:0] a);
    rd_req_i  = 1'b1;
    rd_sel_i  = s;
    rd_addr_i = a;
    tick(1);
    rd_req_i = 1'b0;
    chk({7'h00, rd_valid_o}, 8'h01);
    got = rd_data_o;
    tick(1);
  endtask

  task automatic txc(input logic [7:0] e, input logic f);
    tx_req_i = 1'b1;
    tick(1);
    tx_req_i = 1'b0;
    chk({7'h00, tx_valid_o}, 8'h01);
    chk({7'h00, tx_first_o}, {7'h00, f});
    chk(tx_byte_o, e);
    chk({7'h00, xo_txv}, 8'h00);
    tick(1);
  endtask

  task automatic setm(input logic [1:0] m);
    mode_wr_i = 1'b1;
    mode_i    = m;
    tick(1);
    mode_wr_i = 1'b0;
    tick(1);
    chk({6'h00, mode_o}, {6'h00, m});
  endtask

  // one string from the peer, then room for the alarm to settle
  task automatic send(input logic [7:0] s, input logic sl);
    int n;
    seed = s;
    slow = sl;
    go   = 1'b1;
    tick(1);
    go = 1'b0;
    n  = 0;
    while (busy && n < 400) begin
      tick(1);
      n++;
    end
    if (n >= 400) begin
      failures++;
      wrap_up();
    end
    tick(3);
  endtask

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    rst_n_i = 1'b0;
    {mode_wr_i, mode_i, defaults_i, prov_wr_i, prov_sel_i, prov_addr_i, prov_data_i} = '0;
    {rd_req_i, rd_sel_i, rd_addr_i, tx_req_i, go, slow, seed} = '0;
    failures = 0;
    n_checks = 0;
    tick(20);
    rst_n_i = 1'b1;
    tick(1);
    chk({6'h00, mode_o}, 8'h00);
    chk({7'h00, alarm_o}, 8'h00);
    rd(2'b01, 6'h3F);
    chk(got, 8'h00);
    $display("test reset_state done");
    for (int k = 0; k < 64; k++) begin
      txc(8'h00, k == 0);
    end
    $display("test empty_tx done");
    for (int k = 0; k < 64; k++) begin
      wr(2'b00, 6'(k), 8'h30 + 8'(k));
    end
    for (int k = 0; k < 64; k++) begin
      txc(8'h30 + 8'(k), k == 0);
    end
    rd(2'b00, 6'h05);
    chk(got, 8'h35);
    chk(xo_data, 8'h00);
    $display("test tx_string done");
    setm(2'b01);
    send(8'h10, 1'b0);
    chk({7'h00, learned_o}, 8'h01);
    chk({7'h00, alarm_o}, 8'h00);
    send(8'h10, 1'b1);
    chk({7'h00, alarm_o}, 8'h00);
    send(8'h11, 1'b0);
    chk({7'h00, alarm_o}, 8'h01);
    chk({7'h00, xo_alarm}, 8'h01);
    rd(2'b10, 6'h3F);
    chk(got, 8'h50);
    send(8'h10, 1'b0);
    chk({7'h00, alarm_o}, 8'h00);
    chk({7'h00, xo_alarm}, 8'h00);
    $display("test auto_mode done");
    for (int k = 0; k < 64; k++) begin
      wr(2'b01, 6'(k), 8'h20 + 8'(k));
    end
    setm(2'b10);
    send(8'h20, 1'b0);
    chk({7'h00, alarm_o}, 8'h00);
    send(8'h21, 1'b0);
    chk({7'h00, alarm_o}, 8'h01);
    $display("test manual_mode done");
    // defaults must win over a mode write and a string write in the same cycle
    defaults_i  = 1'b1;
    mode_wr_i   = 1'b1;
    mode_i      = 2'b01;
    prov_wr_i   = 1'b1;
    prov_sel_i  = 2'b01;
    prov_addr_i = 6'h00;
    prov_data_i = 8'hAA;
    tick(1);
    defaults_i = 1'b0;
    mode_wr_i  = 1'b0;
    prov_wr_i  = 1'b0;
    tick(1);
    chk({6'h00, mode_o}, 8'h00);
    chk({7'h00, alarm_o}, 8'h00);
    chk({7'h00, learned_o}, 8'h00);
    rd(2'b01, 6'h00);
    chk(got, 8'h00);
    rd(2'b00, 6'h00);
    chk(got, 8'h00);
    send(8'h55, 1'b0);
    chk({7'h00, alarm_o}, 8'h00);
    $display("test defaults done");
    // unused mode code acts as off; the received selector takes no write, an unused selector reads null
    setm(2'b10);
    mode_wr_i = 1'b1;
    mode_i    = 2'b11;
    tick(1);
    mode_wr_i = 1'b0;
    tick(1);
    chk({6'h00, mode_o}, 8'h00);
    wr(2'b10, 6'h00, 8'h77);
    rd(2'b10, 6'h00);
    chk(got, 8'h55);
    rd(2'b11, 6'h00);
    chk(got, 8'h00);
    $display("test odd_codes done");
    wrap_up();
  end
endmodule

`default_nettype wire
